/* File: verilog/msrc_pkg.sv */
// Shared constants and types for the motor speed run control block.
// Assumes a 100 MHz system clock and a speed input already digitised
// to millivolts by logic on the same clock.
package msrc_pkg;

  // Clock rate and the unit in which ramp times are held (tenths of s).
  localparam int CLK_HZ       = 100_000_000;
  localparam int TIME_UNIT_MS = 100;
  localparam int CYC_PER_UNIT = CLK_HZ / 1000 * TIME_UNIT_MS;

  // Field widths.
  localparam int SPEED_W = 12;
  localparam int TIME_W  = 8;
  localparam int TORQ_W  = 8;
  localparam int MV_W    = 14;
  localparam int SEL_W   = 4;
  localparam int ENTRIES = 16;
  localparam int SYNC_W  = 7;

  // Positions inside the synchroniser vector.
  localparam int SY_FWD  = 0;
  localparam int SY_REV  = 1;
  localparam int SY_SEL  = 2;
  localparam int SY_STOP = 6;

  // Speed scaling limits and defaults (r/min, r/min per volt).
  localparam int MV_PER_V       = 1000;
  localparam int RATED_SPEED    = 3000;
  localparam int SPEED_LIMIT    = 4000;
  localparam int SPEED_GAIN_DEF = 800;
  localparam int SPEED_MAX_DEF  = 4000;
  localparam int SPEED_OFS_LIM  = 2000;

  // Torque scaling limits and defaults (percent, percent per volt).
  localparam int TORQ_LIMIT    = 200;
  localparam int TORQ_GAIN_DEF = 40;
  localparam int TORQ_MAX_DEF  = 200;
  localparam int TORQ_OFS_LIM  = 50;

  // Ramp time range in tenths of a second: 0.2 s to 15 s, default 0.5 s.
  localparam logic [7:0] TIME_MIN = 8'h02;
  localparam logic [7:0] TIME_MAX = 8'h96;
  localparam logic [7:0] TIME_DEF = 8'h05;

  // Reset contents of an operation data entry.
  localparam logic [11:0] ENTRY_SPEED_RST = 12'h000;
  localparam logic [7:0]  ENTRY_TORQ_RST  = 8'hC8;

  // Analog input selection; the codes are the setting values.
  typedef enum logic [1:0] {
    MSRC_ANA_OFF    = 2'h0,
    MSRC_ANA_SPEED  = 2'h1,
    MSRC_ANA_TORQUE = 2'h2
  } msrc_anasel_t;

  // Run state of the direction control.
  typedef enum logic [1:0] {RUN_IDLE, RUN_CW, RUN_CCW} msrc_run_t;

  // One operation data entry.
  typedef struct packed {
    logic [SPEED_W-1:0] speed;
    logic [TIME_W-1:0]  accel;
    logic [TIME_W-1:0]  decel;
    logic [TORQ_W-1:0]  torque;
  } msrc_opdata_t;

  // Scaling configuration of the analog input.
  typedef struct packed {
    msrc_anasel_t         anaSel;
    logic [SPEED_W-1:0]   speedGain;
    logic [SPEED_W-1:0]   speedMax;
    logic signed [11:0]   speedOffset;
    logic [TORQ_W-1:0]    torqGain;
    logic [TORQ_W-1:0]    torqMax;
    logic signed [6:0]    torqOffset;
  } msrc_cfg_t;

  // State of the ramp generator.
  typedef struct packed {
    logic [SPEED_W-1:0] speed;
    logic [31:0]        acc;
  } msrc_ramp_st_t;

  // State of the run control.
  typedef struct packed {
    logic [SYNC_W-1:0]                 sync1;
    logic [SYNC_W-1:0]                 sync2;
    msrc_run_t                         run;
    msrc_opdata_t [ENTRIES-1:0]        opTable;
    logic [SPEED_W-1:0]                target;
    logic [SPEED_W-1:0]                refSpeed;
    logic [TIME_W-1:0]                 accel;
    logic [TIME_W-1:0]                 decel;
    logic [TORQ_W-1:0]                 torque;
    logic                              instant;
    logic [SEL_W-1:0]                  entry;
  } msrc_state_t;

endpackage

/* File: verilog/msrc_ramp.sv */
// Linear speed ramp generator for the run control.
// Assumes target, times and reference speed come from registers on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module msrc_ramp
  import msrc_pkg::*;
#(
  parameter int CYC_UNIT = CYC_PER_UNIT
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic [SPEED_W-1:0] target,
  input  wire logic [SPEED_W-1:0] refSpeed,
  input  wire logic [TIME_W-1:0]  accel,
  input  wire logic [TIME_W-1:0]  decel,
  input  wire logic               instant,
  output logic      [SPEED_W-1:0] speed
);

  msrc_ramp_st_t st_r;   // Registered ramp state.
  msrc_ramp_st_t st_nxt; // Next ramp state.
  logic [31:0]   period; // Cycles for a full swing of refSpeed.
  logic [31:0]   accSum; // Accumulator after this cycle's addition.
  logic          up;     // Ramp is climbing.

  // Bresenham stepping: adding refSpeed each cycle and stepping one r/min
  // per period crossed moves 0 to refSpeed in exactly one period, so no
  // divider is needed.  Only one step is taken per cycle, so the shortest
  // period (0.2 s) must span at least 4000 cycles: a CYC_UNIT of 2000 or
  // more keeps the slope exact for every reference speed.
  always_comb begin
    st_nxt = st_r;
    up     = target > st_r.speed;
    period = 32'(up ? accel : decel) * 32'(CYC_UNIT);
    accSum = st_r.acc + 32'(refSpeed);
    if (instant) begin
      st_nxt.speed = '0;
      st_nxt.acc   = '0;
    end else if (st_r.speed == target) begin
      st_nxt.acc = '0;
    end else if (accSum >= period) begin
      st_nxt.acc   = accSum - period;
      st_nxt.speed = up ? st_r.speed + 12'h001 : st_r.speed - 12'h001;
    end else begin
      st_nxt.acc = accSum;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign speed = st_r.speed;

  // Speed moves one step at a time except for an instant stop.
  property p_step;
    @(posedge clk_sys) disable iff (!rst_n)
      !$past(instant) |-> (speed - $past(speed) <= 12'h001 ||
                           $past(speed) - speed <= 12'h001);
  endproperty
  a_ramp_step_one: assert property (p_step)
    else $error("ramp speed jumped by more than one step");

  a_instant_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n) instant |=> speed == '0)
    else $error("instant stop did not zero the speed");

  a_ramp_holds: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      (speed == target && !instant && $stable(target)) |=> $stable(speed))
    else $error("speed drifted away from a reached target");

endmodule
`default_nettype wire

/* File: verilog/msrc_run_control.sv */
// Run/stop control and analog command scaling for a brushless motor drive.
// Assumes run and select inputs are asynchronous pins, analogMv and all
// configuration come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Forward input held: drive clockwise, release stops.
// - Reverse input held: drive counterclockwise, release stops.
// - Both run inputs: instantaneous stop.
// - Stop-mode high ramps down, low stops instantly.
// - Analog speed uses entry zero ramp times.
// - Analog ramp times span standstill to rated speed.
// - Digital entries ramp between standstill and own speed.
// - Analog speed scaled by gain, 0 to 4000.
// - Analog speed limited to maximum, default 4000.
// - Signed speed offset added, plus or minus 2000.
// - Analog torque scaled by percent per volt gain.
// - Analog torque clamped to maximum, 0 to 200.
// - Signed torque offset added, plus or minus 50.
// - Four select bits choose one of sixteen entries.
// - Selection setting picks digital, analog speed, torque.
// - Ramp times accepted from 0.2 to 15 s.
module msrc_run_control
  import msrc_pkg::*;
#(
  parameter int CYC_UNIT = CYC_PER_UNIT
) (
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               forwardRunIn,
  input  wire logic               reverseRunIn,
  input  wire logic               stopModeIn,
  input  wire logic [SEL_W-1:0]   dataSelectIn,
  input  wire logic [MV_W-1:0]    analogMv,
  input  wire msrc_cfg_t          cfg,
  input  wire logic               tableWrEn,
  input  wire logic [SEL_W-1:0]   tableWrIdx,
  input  wire msrc_opdata_t       tableWrData,
  output logic                    driveCw,
  output logic                    driveCcw,
  output logic      [SPEED_W-1:0] speedCmd,
  output logic      [TORQ_W-1:0]  torqueLimit,
  output logic      [SEL_W-1:0]   activeEntry
);

  msrc_state_t        st_r;       // Registered control state.
  msrc_state_t        st_nxt;     // Next control state.
  logic               forward_run_input;        // Synchronised forward run input.
  logic               reverse_run_input;        // Synchronised reverse run input.
  logic               stopRamp;   // Synchronised stop-mode input.
  logic [SEL_W-1:0]   sel;        // Synchronised entry select.
  logic               anaSpeed;   // Analog speed applies this cycle.
  msrc_opdata_t       ent;        // Currently selected entry.
  msrc_opdata_t       ent0;       // Entry zero.
  msrc_opdata_t       wrClamped;  // Write data forced into range.
  logic [SPEED_W-1:0] gainSat;    // Speed gain limited to its range.
  logic [SPEED_W-1:0] maxSat;     // Speed maximum limited to its range.
  logic [25:0]        spdProd;    // Speed gain times millivolts.
  logic signed [31:0] spdSum;     // Scaled speed plus offset.
  logic [SPEED_W-1:0] anaSpd;     // Saturated analog speed command.
  logic [TORQ_W-1:0]  tqMaxSat;   // Torque maximum limited to range.
  logic [21:0]        tqProd;     // Torque gain times millivolts.
  logic signed [31:0] tqSum;      // Scaled torque plus offset.
  logic [TORQ_W-1:0]  anaTq;      // Saturated analog torque limit.
  logic               keepCw;     // Clockwise request stands.
  logic               keepCcw;    // Counterclockwise request stands.
  logic               both;       // Both run inputs asserted.
  logic               stopping;   // Running state with its request gone.
  logic [SPEED_W-1:0] rampSpeed;  // Present speed from the ramp.

  // Clamp a ramp time into the accepted 0.2 s to 15 s window.
  function automatic logic [TIME_W-1:0] clampTime(
    input logic [TIME_W-1:0] t
  );
    logic [TIME_W-1:0] r;
    r = t;
    if (t < TIME_MIN) begin
      r = TIME_MIN;
    end else if (t > TIME_MAX) begin
      r = TIME_MAX;
    end
    return r;
  endfunction

  // Unpack the synchronised pins; only the second stage is read.
  assign forward_run_input      = st_r.sync2[SY_FWD];
  assign reverse_run_input      = st_r.sync2[SY_REV];
  assign stopRamp = st_r.sync2[SY_STOP];
  assign sel      = st_r.sync2[SY_SEL +: SEL_W];

  // Analog speed scaling.  The offset applies after the gain so that a
  // negative offset can never make the command turn the motor backwards:
  // the sum saturates at zero.
  always_comb begin
    gainSat = (cfg.speedGain > 12'(SPEED_LIMIT)) ? 12'(SPEED_LIMIT)
                                                 : cfg.speedGain;
    maxSat  = (cfg.speedMax > 12'(SPEED_LIMIT)) ? 12'(SPEED_LIMIT)
                                                : cfg.speedMax;
    spdProd = 26'(gainSat) * 26'(analogMv);
    if (cfg.speedOffset > 12'(SPEED_OFS_LIM)) begin
      spdSum = 32'(SPEED_OFS_LIM);
    end else if (cfg.speedOffset < -12'(SPEED_OFS_LIM)) begin
      spdSum = -32'(SPEED_OFS_LIM);
    end else begin
      spdSum = 32'(cfg.speedOffset);
    end
    spdSum = spdSum + $signed({6'h00, spdProd / 26'(MV_PER_V)});
    if (spdSum < 0) begin
      anaSpd = '0;
    end else if (spdSum > $signed(32'(maxSat))) begin
      anaSpd = maxSat;
    end else begin
      anaSpd = spdSum[SPEED_W-1:0];
    end
  end

  // Analog torque scaling, the same shape as the speed path.
  always_comb begin
    tqMaxSat = (cfg.torqMax > 8'(TORQ_LIMIT)) ? 8'(TORQ_LIMIT)
                                              : cfg.torqMax;
    tqProd   = 22'(cfg.torqGain) * 22'(analogMv);
    if (cfg.torqOffset > 7'(TORQ_OFS_LIM)) begin
      tqSum = 32'(TORQ_OFS_LIM);
    end else if (cfg.torqOffset < -7'(TORQ_OFS_LIM)) begin
      tqSum = -32'(TORQ_OFS_LIM);
    end else begin
      tqSum = 32'(cfg.torqOffset);
    end
    tqSum = tqSum + $signed({10'h000, tqProd / 22'(MV_PER_V)});
    if (tqSum < 0) begin
      anaTq = '0;
    end else if (tqSum > $signed(32'(tqMaxSat))) begin
      anaTq = tqMaxSat;
    end else begin
      anaTq = tqSum[TORQ_W-1:0];
    end
  end

  // Write data is forced into range so the table never holds a value the
  // ramp cannot honour.
  always_comb begin
    wrClamped       = tableWrData;
    wrClamped.accel = clampTime(tableWrData.accel);
    wrClamped.decel = clampTime(tableWrData.decel);
    if (tableWrData.speed > 12'(SPEED_LIMIT)) begin
      wrClamped.speed = 12'(SPEED_LIMIT);
    end
    if (tableWrData.torque > 8'(TORQ_LIMIT)) begin
      wrClamped.torque = 8'(TORQ_LIMIT);
    end
  end

  // Main next-state process: synchroniser, table, direction and commands.
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = {stopModeIn, dataSelectIn, reverseRunIn, forwardRunIn};
    st_nxt.sync2 = st_r.sync1;
    if (tableWrEn) begin
      st_nxt.opTable[tableWrIdx] = wrClamped;
    end

    ent      = st_r.opTable[sel];
    ent0     = st_r.opTable[0];
    st_nxt.entry = sel;
    // analog speed only for entry zero
    anaSpeed = (cfg.anaSel == MSRC_ANA_SPEED) && (sel == '0);

    both    = forward_run_input && reverse_run_input;
    keepCw  = (st_r.run == RUN_CW) && forward_run_input && !reverse_run_input;
    keepCcw = (st_r.run == RUN_CCW) && reverse_run_input && !forward_run_input;
    stopping = (st_r.run != RUN_IDLE) && !keepCw && !keepCcw;

    // Direction state.  A reversal first brings the motor to standstill
    // in the old direction; the new one starts from zero speed.
    case (st_r.run)
      RUN_IDLE: begin
        if (forward_run_input && !reverse_run_input) begin
          st_nxt.run = RUN_CW;
        end else if (reverse_run_input && !forward_run_input) begin
          st_nxt.run = RUN_CCW;
        end
      end
      RUN_CW, RUN_CCW: begin
        // both inputs drop to idle at once
        if (both || (stopping && rampSpeed == '0)) begin
          st_nxt.run = RUN_IDLE;
        end
      end
      default: begin
        st_nxt.run = RUN_IDLE;
      end
    endcase

    // Target: the command while a request stands, otherwise standstill.
    if (keepCw || keepCcw) begin
      st_nxt.target = anaSpeed ? anaSpd : ent.speed;
    end else begin
      st_nxt.target = '0;
    end
    // stop mode picks ramp or instant
    st_nxt.instant = both || (stopping && !stopRamp);

    if (anaSpeed) begin
      // entry zero times for analog speed
      st_nxt.accel    = ent0.accel;
      st_nxt.decel    = ent0.decel;
      st_nxt.refSpeed = 12'(RATED_SPEED);
    end else begin
      // entry times over its own speed
      st_nxt.accel    = ent.accel;
      st_nxt.decel    = ent.decel;
      st_nxt.refSpeed = (ent.speed == '0) ? 12'h001 : ent.speed;
    end

    st_nxt.torque = (cfg.anaSel == MSRC_ANA_TORQUE) ? anaTq : ent.torque;
  end

  // State register; the table resets to default entries.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r     <= '0;
      st_r.run <= RUN_IDLE;
      for (int i = 0; i < ENTRIES; i++) begin
        st_r.opTable[i] <= '{speed: ENTRY_SPEED_RST, accel: TIME_DEF,
                             decel: TIME_DEF, torque: ENTRY_TORQ_RST};
      end
      st_r.accel  <= TIME_DEF;
      st_r.decel  <= TIME_DEF;
      st_r.torque <= ENTRY_TORQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ramp generator drives the speed command.
  msrc_ramp #(
    .CYC_UNIT (CYC_UNIT)
  ) u_ramp (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .target   (st_r.target),
    .refSpeed (st_r.refSpeed),
    .accel    (st_r.accel),
    .decel    (st_r.decel),
    .instant  (st_r.instant),
    .speed    (rampSpeed)
  );

  assign speedCmd    = rampSpeed;
  assign driveCw     = st_r.run == RUN_CW;
  assign driveCcw    = st_r.run == RUN_CCW;
  assign torqueLimit = st_r.torque;
  assign activeEntry = st_r.entry;

  // Both run inputs: idle and zero speed within two cycles.
  sequence s_both;
    forward_run_input && reverse_run_input;
  endsequence
  a_both_stop: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      s_both |=> !driveCw && !driveCcw ##1 speedCmd == '0)
    else $error("both run inputs did not stop the motor");

  a_cw_start: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      (st_r.run == RUN_IDLE && forward_run_input && !reverse_run_input) |=> driveCw)
    else $error("forward request did not select clockwise");

  a_ccw_start: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      (st_r.run == RUN_IDLE && reverse_run_input && !forward_run_input) |=> driveCcw)
    else $error("reverse request did not select counterclockwise");

  a_torque_bound: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      torqueLimit <= 8'(TORQ_LIMIT))
    else $error("torque limit above its ceiling");

  a_stop_mode: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      (stopping && !both) |=> st_r.instant == !$past(stopRamp))
    else $error("stop behaviour does not follow stop-mode input");

  a_analog_times: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
      anaSpeed |=> st_r.accel == $past(ent0.accel) &&
                   st_r.refSpeed == 12'(RATED_SPEED))
    else $error("analog speed did not use entry zero times");

endmodule
`default_nettype wire

/* File: verif/msrc_ctl_model.sv */
// Model of the outside controller that drives the run and select pins.
// Assumes the bench calls apply() and that clk_sys is the block clock.
`timescale 1ns/1ps
`default_nettype none
module msrc_ctl_model
  import msrc_pkg::*;
#(
  parameter int HOLD_CYC = 2
) (
  input  wire logic             clk_sys,
  output logic                  fwdPin,
  output logic                  revPin,
  output logic                  stopModePin,
  output logic      [SEL_W-1:0] selPin
);
  // Pins start idle so that no request is seen out of reset.
  initial begin
    fwdPin      = 1'b0;
    revPin      = 1'b0;
    stopModePin = 1'b1;
    selPin      = 4'h0;
  end

  // Applies one pin setting on a falling edge, then holds it.
  task automatic apply(input logic f, input logic r, input logic sm,
                       input logic [SEL_W-1:0] s);
    if ((fwdPin && !f && r) || (revPin && !r && f)) begin
      @(negedge clk_sys);
      fwdPin = 1'b0;
      revPin = 1'b0;
      repeat (HOLD_CYC) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    fwdPin      = f;
    revPin      = r;
    stopModePin = sm;
    selPin      = s;
    repeat (HOLD_CYC) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* File: verif/msrc_run_control_bench.sv */
// Self-checking bench for the motor run control block.
// Assumes the package, design files and controller model come first.
`timescale 1ns/1ps
`default_nettype none
module msrc_run_control_bench
  import msrc_pkg::*;
;
  logic               clk_sys;
  logic               rst_n;
  logic               forward_run_input;
  logic               reverse_run_input;
  logic               stopMode;
  logic [SEL_W-1:0]   sel;
  logic [MV_W-1:0]    analogMv;
  msrc_cfg_t          cfg;
  logic               tableWrEn;
  logic [SEL_W-1:0]   tableWrIdx;
  msrc_opdata_t       tableWrData;
  logic               driveCw;
  logic               driveCcw;
  logic [SPEED_W-1:0] speedCmd;
  logic [TORQ_W-1:0]  torqueLimit;
  logic [SEL_W-1:0]   activeEntry;
  int                 num_errors;
  int                 cmp_count;
  logic [31:0]        seed;
  int                 mvQ[$];
  int                 g;
  int                 mx;
  int                 of;
  int                 mv;
  int                 ex;

  // The shortest unit at which the ramp still steps at most once a cycle;
  // a 0.2 s ramp over its full reference then spans RAMP_CYC cycles.
  localparam int UNIT_CYC = 2000;
  localparam int RAMP_CYC = 2 * UNIT_CYC;

  msrc_run_control #(.CYC_UNIT(UNIT_CYC)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .forwardRunIn(forward_run_input),
    .reverseRunIn(reverse_run_input), .stopModeIn(stopMode), .dataSelectIn(sel),
    .analogMv(analogMv), .cfg(cfg), .tableWrEn(tableWrEn),
    .tableWrIdx(tableWrIdx), .tableWrData(tableWrData),
    .driveCw(driveCw), .driveCcw(driveCcw), .speedCmd(speedCmd),
    .torqueLimit(torqueLimit), .activeEntry(activeEntry));

  msrc_ctl_model #(.HOLD_CYC(2)) ctl (
    .clk_sys(clk_sys), .fwdPin(forward_run_input), .revPin(reverse_run_input),
    .stopModePin(stopMode), .selPin(sel));

  // Free running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Next state of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random integer in lo..hi, drawn from the shift register.
  function automatic int pick(input int lo, input int hi);
    seed = lfsr(seed);
    return lo + int'(seed[23:0]) % (hi - lo + 1);
  endfunction

  // Reference scaling: gain times volts plus offset, then saturated.
  function automatic int scale(input int gn, input int mxv, input int ofs,
                               input int mvv);
    int v;
    v = gn * mvv / 1000 + ofs;
    if (v > mxv) v = mxv;
    if (v < 0) v = 0;
    return v;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Compares one observed value with its expected value.
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  // Waits for the speed command, then checks value and elapsed cycles.
  task automatic run_to(input int e, input int lo, input int hi);
    int n;
    n = 0;
    while (speedCmd !== 12'(e) && n <= hi) begin
      @(negedge clk_sys);
      n++;
    end
    if (n > hi) begin
      num_errors++;
      $display("ERROR speedCmd expected %0d seen %0d", e, speedCmd);
      give_verdict();
    end
    chk("ramp cycles in window", 16'h0001, 16'(n >= lo && n <= hi));
  endtask

  // Writes one operation data entry with equal ramp times.
  task automatic wr_entry(input int idx, input int spd, input int t);
    @(negedge clk_sys);
    tableWrEn   = 1'b1;
    tableWrIdx  = 4'(idx);
    tableWrData = '{speed: 12'(spd), accel: 8'(t), decel: 8'(t),
                    torque: 8'hC8};
    @(negedge clk_sys);
    tableWrEn   = 1'b0;
  endtask

  // Sets the speed scaling and the input voltage.
  task automatic set_spd(input int gn, input int mxv, input int ofs,
                         input int mvv);
    @(negedge clk_sys);
    cfg.speedGain   = 12'(gn);
    cfg.speedMax    = 12'(mxv);
    cfg.speedOffset = 12'(ofs);
    analogMv        = 14'(mvv);
  endtask

  // Watchdog so that a stuck design still reaches the verdict.
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    give_verdict();
  end

  initial begin
    num_errors  = 0;
    cmp_count   = 0;
    seed        = 32'h7E30A0E6;
    rst_n       = 1'b0;
    analogMv    = 14'h0000;
    tableWrEn   = 1'b0;
    tableWrIdx  = 4'h0;
    tableWrData = '0;
    cfg = '{MSRC_ANA_SPEED, 12'h320, 12'hFA0, 12'h000, 8'h28, 8'hC8, 7'h00};
    repeat (16) @(negedge clk_sys);
    chk("driveCw", 16'h0000, 16'(driveCw));
    chk("speedCmd", 16'h0000, 16'(speedCmd));
    chk("torqueLimit", 16'h00C8, 16'(torqueLimit));
    chk("activeEntry", 16'h0000, 16'(activeEntry));
    rst_n = 1'b1;
    $display("test reset done");
    // Analog ramp over entry zero times: 0.2 s from standstill to rated.
    wr_entry(0, 0, 2);
    set_spd(300, 4000, 0, 10000);
    ctl.apply(1'b1, 1'b0, 1'b1, 4'h0);
    run_to(3000, RAMP_CYC, RAMP_CYC + 8);
    chk("driveCw", 16'h0001, 16'(driveCw));
    chk("driveCcw", 16'h0000, 16'(driveCcw));
    $display("test analog ramp done");
    // Random gain, maximum and offset while running forward.
    mvQ.push_back(10000);
    repeat (5) mvQ.push_back(pick(0, 10000));
    foreach (mvQ[i]) begin
      g  = pick(0, 4000);
      mx = pick(10, 4000);
      of = pick(-2000, 2000);
      ex = scale(g, mx, of, mvQ[i]);
      set_spd(g, mx, of, mvQ[i]);
      run_to(ex, 0, 3 * UNIT_CYC);
      chk("speedCmd", 16'(ex), 16'(speedCmd));
    end
    $display("test analog scaling done");
    // Release with stop mode high must ramp down.
    set_spd(300, 4000, 0, 10000);
    run_to(3000, 0, 3 * UNIT_CYC);
    ctl.apply(1'b0, 1'b0, 1'b1, 4'h0);
    run_to(0, RAMP_CYC, RAMP_CYC + 8);
    repeat (2) @(negedge clk_sys);
    chk("driveCw", 16'h0000, 16'(driveCw));
    // Reverse run, then release with stop mode low stops at once.
    ctl.apply(1'b0, 1'b1, 1'b0, 4'h0);
    run_to(3000, RAMP_CYC, RAMP_CYC + 8);
    chk("driveCcw", 16'h0001, 16'(driveCcw));
    ctl.apply(1'b0, 1'b0, 1'b0, 4'h0);
    run_to(0, 0, 6);
    repeat (2) @(negedge clk_sys);
    chk("driveCcw", 16'h0000, 16'(driveCcw));
    $display("test stop modes done");
    // Both run inputs stop instantly even with stop mode high.
    ctl.apply(1'b1, 1'b0, 1'b1, 4'h0);
    run_to(3000, RAMP_CYC, RAMP_CYC + 8);
    ctl.apply(1'b1, 1'b1, 1'b1, 4'h0);
    run_to(0, 0, 6);
    chk("driveCw", 16'h0000, 16'(driveCw));
    ctl.apply(1'b0, 1'b0, 1'b1, 4'h0);
    $display("test both inputs done");
    // Digital entry five ramps between standstill and its own speed.
    @(negedge clk_sys);
    cfg.anaSel = MSRC_ANA_OFF;
    wr_entry(5, 1000, 2);
    ctl.apply(1'b0, 1'b1, 1'b1, 4'h5);
    run_to(1000, RAMP_CYC, RAMP_CYC + 8);
    chk("activeEntry", 16'h0005, 16'(activeEntry));
    ctl.apply(1'b0, 1'b0, 1'b1, 4'h5);
    run_to(0, RAMP_CYC, RAMP_CYC + 8);
    $display("test digital entry done");
    // Analog torque limit with random gain, maximum and offset.
    @(negedge clk_sys);
    cfg.anaSel = MSRC_ANA_TORQUE;
    repeat (6) begin
      g  = pick(0, 60);
      mx = pick(0, 200);
      of = pick(-50, 50);
      mv = pick(0, 10000);
      @(negedge clk_sys);
      cfg.torqGain   = 8'(g);
      cfg.torqMax    = 8'(mx);
      cfg.torqOffset = 7'(of);
      analogMv       = 14'(mv);
      ex             = scale(g, mx, of, mv);
      repeat (3) @(negedge clk_sys);
      chk("torqueLimit", 16'(ex), 16'(torqueLimit));
    end
    $display("test torque limit done");
    give_verdict();
  end
endmodule
`default_nettype wire
